//--- pkg/hpc_pkg.sv
/*
 * Constants, field layouts and carrier types of the hydronic pump controller.
 * Assumes a 25 MHz system clock and temperatures given in whole degrees Celsius.
 */
package hpc_pkg;
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_MS     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int EXER_RUN_S  = 30;
  localparam int IDLE_DAYS   = 5;
  localparam int IDLE_S      = IDLE_DAYS * 24 * 3600;
  localparam int BOOT_MIN    = 5;
  localparam int BOOT_S      = BOOT_MIN * 60;
  localparam int UNLOCK_MIN  = 30;
  localparam int UNLOCK_S    = UNLOCK_MIN * 60;
  localparam int CLEAN_S     = 60;
  localparam logic signed [9:0] FREEZE_C = 10'sh004;
  localparam logic [7:0] AFTERBURN_C = 8'h0A;
  localparam logic [7:0] HPC_WIDTH_C = 8'h00;

  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_THR    = 6'h04;
  localparam logic [5:0] OFS_LIM    = 6'h08;
  localparam logic [5:0] OFS_PIN    = 6'h0C;
  localparam logic [5:0] OFS_CODE   = 6'h10;
  localparam logic [5:0] OFS_RTC    = 6'h14;
  localparam logic [5:0] OFS_STAT   = 6'h18;
  localparam logic [5:0] OFS_IRQ    = 6'h1C;
  localparam logic [5:0] OFS_MASK   = 6'h20;

  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_TEST_LSB  = 2;
  localparam int CTRL_CLEAN_BIT = 4;

  localparam int IRQ_UNLOCK_END = 0;
  localparam int IRQ_CLEAN_END  = 1;
  localparam int IRQ_FREEZE     = 2;
  localparam int IRQ_EXERCISE   = 3;
  localparam int IRQ_W          = 4;

  localparam logic [31:0] THR_RST  = 32'h2803_2D50;
  localparam logic [31:0] LIM_RST  = 32'h000A_025F;
  localparam logic [15:0] CODE_RST = 16'h1234;
  localparam logic [31:0] RTC_RST  = 32'h0000_0001;

  typedef enum logic [1:0] {
    HPC_AIR     = 2'h0,
    HPC_WATER_1 = 2'h1,
    HPC_WATER_2 = 2'h2
  } hpc_mode_e;

  typedef struct packed {
    logic signed [9:0] flue;
    logic signed [9:0] stove;
    logic signed [9:0] buf_hi;
    logic signed [9:0] buf_lo;
  } hpc_temps_s;

  typedef struct packed {
    logic [7:0] circ_upper_threshold;
    logic [7:0] stove_buffer_delta;
    logic [7:0] stove_water_min;
    logic [7:0] loading_flue_threshold;
  } hpc_thr_s;

  typedef struct packed {
    logic [7:0] spare;
    logic [7:0] min_on_s;
    logic [7:0] hyst_c;
    logic [7:0] alarm_max;
  } hpc_lim_s;
endpackage

//--- testbench/hpc_plant.sv
/*
 * Sensor model for the pump controller bench: temperature probes and their
 * health flags. Assumes the bench sets target readings just after clock edges.
 */
`timescale 1ns/100ps
module hpc_plant
  import hpc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire hpc_temps_s tgt_i,
  input  wire logic       hi_ok_i,
  input  wire logic       lo_ok_i,
  output hpc_temps_s      temps_o,
  output logic            hi_ok_o,
  output logic            lo_ok_o
);
  initial temps_o = '0;
  // A dead probe never holds its last reading; it wanders by an odd step so
  // that a tick-rate sampler cannot alias it into a stable value.
  always @(posedge clk_i) begin
    temps_o.flue   <= tgt_i.flue;
    temps_o.stove  <= tgt_i.stove;
    temps_o.buf_hi <= hi_ok_i ? tgt_i.buf_hi : temps_o.buf_hi + 10'sh0C7;
    temps_o.buf_lo <= lo_ok_i ? tgt_i.buf_lo : temps_o.buf_lo + 10'sh0C7;
    hi_ok_o        <= hi_ok_i;
    lo_ok_o        <= lo_ok_i;
  end
endmodule

//--- testbench/hydronic_pump_controller_test.sv
/*
 * Self-checking bench of the pump controller: Avalon register tasks and one
 * task per scenario. Assumes hpc_top is built with a ten-cycle control tick.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module hydronic_pump_controller_test
  import hpc_pkg::*;
;
  localparam int TN = 10;
  logic        clk_i, srst_i, read_i, write_i, touch_i, hi_ok, lo_ok, hi_s, lo_s;
  logic [5:0]  address_i;
  logic [31:0] writedata_i, rd, readdata_o;
  logic        waitrequest_o, buf_pump_o, circ_pump_o, touch_o, nv_save_o, irq_o;
  logic [7:0]  clean_left_o;
  hpc_temps_s  tgt, temps;
  int          error_cnt, samples_checked, saves, s0;

  hpc_top #(.TICK_N(TN)) hpc_top_i (
    .clk_i(clk_i), .srst_i(srst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(4'hF),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .temps_i(temps),
    .buf_hi_ok_i(hi_s), .buf_lo_ok_i(lo_s), .touch_i(touch_i),
    .buf_pump_o(buf_pump_o), .circ_pump_o(circ_pump_o), .touch_o(touch_o),
    .clean_left_o(clean_left_o), .nv_save_o(nv_save_o), .irq_o(irq_o));
  hpc_plant hpc_plant_i (.clk_i(clk_i), .tgt_i(tgt), .hi_ok_i(hi_ok),
    .lo_ok_i(lo_ok), .temps_o(temps), .hi_ok_o(hi_s), .lo_ok_o(lo_s));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (nv_save_o === 1'b1) saves++;

  function automatic hpc_temps_s tp(int f, int s, int h, int l);
    tp = '{flue: 10'(f), stove: 10'(s), buf_hi: 10'(h), buf_lo: 10'(l)};
  endfunction

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    address_i   <= a;
    writedata_i <= d;
    write_i     <= w;
    read_i      <= ~w;
    // The slave paces the access; only the watchdog ends a wait that never finishes.
    do begin
      @(posedge clk_i);
    end while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask
  task automatic wp(input logic b, input logic c, input int lim);
    for (int n = 0; n < lim && {buf_pump_o, circ_pump_o} !== {b, c}; n++) @(posedge clk_i);
    `CHK("pumps", {b, c}, {buf_pump_o, circ_pump_o})
  endtask
  task automatic rst();
    @(posedge clk_i);
    srst_i <= 1'b1;
    tgt    <= tp(20, 20, 20, 20);
    hi_ok  <= 1'b1;
    lo_ok  <= 1'b1;
    touch_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
  endtask

  task automatic t_reset();
    rst();
    `CHK("pumps", 2'b00, {buf_pump_o, circ_pump_o})
    `CHK("irq", 1'b0, irq_o)
    rdc("ctrl", OFS_CTRL, 32'h0000_0001);
    rdc("thr", OFS_THR, THR_RST);
    rdc("unmapped", 6'h24, 32'h0000_0000);
  endtask
  task automatic t_pin();
    rst();
    s0 = saves;
    wr(OFS_THR, 32'h2803_2D00);
    rdc("locked thr", OFS_THR, THR_RST);
    `CHK("saves", s0, saves)
    wr(OFS_PIN, 32'h0000_1235);
    wr(OFS_THR, 32'h2803_2D00);
    rdc("bad pin thr", OFS_THR, THR_RST);
    wr(OFS_PIN, {16'h0000, CODE_RST});
    bus(1'b0, OFS_STAT, 32'h0);
    `CHK("unlocked", 1'b1, rd[3])
    wr(OFS_THR, 32'h2803_2D00);
    repeat (2) @(posedge clk_i);
    `CHK("saves", s0 + 1, saves)
    rdc("open thr", OFS_THR, 32'h2803_2D00);
    hi_ok <= 1'b0;
    lo_ok <= 1'b0;
    tgt   <= tp(20, 50, 20, 20);
    wp(1'b1, 1'b1, 3 * TN);
    wr(OFS_MASK, 32'h0000_0001);
    repeat (1800 * TN + 40) @(posedge clk_i);
    bus(1'b0, OFS_STAT, 32'h0);
    `CHK("unlocked", 1'b0, rd[3])
    `CHK("irq", 1'b1, irq_o)
    wr(OFS_IRQ, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
  endtask
  task automatic t_buffer();
    rst();
    tgt <= tp(100, 46, 30, 40);
    repeat (3 * TN) @(posedge clk_i);
    `CHK("pumps", 2'b00, {buf_pump_o, circ_pump_o})
    tgt <= tp(100, 60, 30, 40);
    wp(1'b1, 1'b0, 3 * TN);
    tgt <= tp(100, 60, 43, 40);
    wp(1'b1, 1'b1, 3 * TN);
    tgt <= tp(100, 60, 20, 40);
    repeat (5 * TN) @(posedge clk_i);
    `CHK("pumps", 2'b11, {buf_pump_o, circ_pump_o})
    wp(1'b1, 1'b0, 12 * TN);
    tgt <= tp(20, 88, 20, 40);
    repeat (12 * TN) @(posedge clk_i);
    `CHK("afterburn", 1'b1, buf_pump_o)
    tgt <= tp(20, 80, 20, 40);
    wp(1'b0, 1'b0, 3 * TN);
  endtask
  task automatic t_freeze();
    rst();
    tgt <= tp(20, 2, 2, 20);
    wp(1'b1, 1'b1, 3 * TN);
    bus(1'b0, OFS_IRQ, 32'h0);
    `CHK("freeze flag", 1'b1, rd[IRQ_FREEZE])
    wr(OFS_CTRL, 32'h0000_0000);
    wp(1'b0, 1'b0, 3 * TN);
    wr(OFS_CTRL, 32'h0000_000C);
    wp(1'b1, 1'b1, 3 * TN);
  endtask
  task automatic t_sensors();
    rst();
    wr(OFS_CTRL, 32'h0000_0002);
    hi_ok <= 1'b0;
    lo_ok <= 1'b0;
    tgt   <= tp(100, 20, 20, 20);
    wp(1'b1, 1'b1, 3 * TN);
    rst();
    hi_ok <= 1'b0;
    tgt   <= tp(20, 20, 20, 30);
    repeat (5 * TN) @(posedge clk_i);
    `CHK("pumps", 2'b00, {buf_pump_o, circ_pump_o})
    tgt <= tp(20, 20, 20, 45);
    wp(1'b0, 1'b1, 3 * TN);
  endtask
  task automatic t_exercise();
    rst();
    repeat (290 * TN) @(posedge clk_i);
    `CHK("pumps", 2'b00, {buf_pump_o, circ_pump_o})
    wp(1'b1, 1'b1, 15 * TN);
    repeat (25 * TN) @(posedge clk_i);
    `CHK("pumps", 2'b11, {buf_pump_o, circ_pump_o})
    wp(1'b0, 1'b0, 10 * TN);
  endtask
  task automatic t_clean();
    rst();
    touch_i <= 1'b1;
    wr(OFS_MASK, 32'h0000_0002);
    wr(OFS_CTRL, 32'h0000_0011);
    repeat (3) @(posedge clk_i);
    `CHK("touch", 1'b0, touch_o)
    `CHK("left", 1'b1, clean_left_o inside {8'h3B, 8'h3C})
    repeat (55 * TN) @(posedge clk_i);
    `CHK("touch", 1'b0, touch_o)
    for (int n = 0; n < 8 * TN && touch_o !== 1'b1; n++) @(posedge clk_i);
    `CHK("touch", 1'b1, touch_o)
    `CHK("left", 8'h00, clean_left_o)
    `CHK("irq", 1'b1, irq_o)
  endtask
  task automatic t_rtc();
    wr(OFS_RTC, 32'h0000_0000);
    bus(1'b0, OFS_RTC, 32'h0);
    `CHK("weekday", 3'h1, rd[2:0])
    wr(OFS_RTC, 32'h053B_1707);
    rdc("rtc", OFS_RTC, 32'h053B_1707);
    // One minute later the clock rolls over midnight and Sunday wraps to Monday.
    repeat (62 * TN) @(posedge clk_i);
    rdc("rtc wrap", OFS_RTC, 32'h0500_0001);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge clk_i);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    srst_i          = 1'b1;
    read_i          = 1'b0;
    write_i         = 1'b0;
    address_i       = '0;
    writedata_i     = '0;
    touch_i         = 1'b0;
    hi_ok           = 1'b1;
    lo_ok           = 1'b1;
    tgt             = '0;
    error_cnt       = 0;
    samples_checked = 0;
    saves           = 0;
    t_reset();
    t_rtc();
    t_buffer();
    t_freeze();
    t_sensors();
    t_clean();
    t_exercise();
    t_pin();
    report_and_stop();
  end
endmodule

//--- verilog/hpc_top.sv
/*
 * Hydronic pump controller: buffer loading pump and circulating pump control,
 * PIN unlock, touch cleaning lockout, weekday clock and setting-save strobe.
 * Assumes sensor readings and fault flags are synchronous to clk_i and that
 * an Avalon-MM master with waitrequest reaches the registers.
 */
`timescale 1ns/100ps
// Summary of operation
// - Mode zero air only; 1 or 2 water
// - Circulating pump on above upper threshold
// - Temperature and minimum-time hysteresis on pumps
// - One buffer sensor failed: use the other
// - No buffer sensors: flue threshold drives pumps
// - Flue threshold zero ignores flue temperature except in the after-burn check
// - Pump forced on below four degrees
// - Idle five days: thirty second exercise run
// - Idle during first five minutes: exercise run
// - Test mode forces pump outputs on
// - Buffer pump needs flue, water, delta conditions
// - After burn, run near stove alarm maximum
// - Protected writes need PIN, thirty minute unlock
// - Cleaning request blocks touch sixty seconds
// - Weekday one Monday to seven Sunday
// - Each changed setting triggers a save
module hpc_top
  import hpc_pkg::*;
#(
  parameter int TICK_N = TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic [5:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  input  wire hpc_temps_s  temps_i,
  input  wire logic        buf_hi_ok_i,
  input  wire logic        buf_lo_ok_i,
  input  wire logic        touch_i,
  output logic             buf_pump_o,
  output logic             circ_pump_o,
  output logic             touch_o,
  output logic [7:0]       clean_left_o,
  output logic             nv_save_o,
  output logic             irq_o
);
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return old;
  endfunction

  // Above the limit, with the margin only required while the pump is off.
  function automatic logic above(input logic signed [9:0] t, input logic [7:0] lim,
                                 input logic on, input logic [7:0] h);
    logic signed [11:0] ref_v;
    ref_v = $signed({4'h0, lim}) + (on ? 12'sh000 : $signed({4'h0, h}));
    return $signed({{2{t[9]}}, t}) > ref_v;
  endfunction

  logic [24:0] div;
  logic        tick;
  logic        req;
  logic        acc;
  logic [31:0] ctrl;
  hpc_thr_s    thr;
  hpc_lim_s    lim;
  logic [15:0] code;
  logic [31:0] rtc;
  logic [5:0]  sec;
  logic [IRQ_W-1:0] irq_st;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] ev;
  logic [10:0] unlock_cnt;
  logic        unlocked;
  logic [8:0]  boot_cnt;
  logic        boot_end;
  hpc_mode_e   mode;
  logic [1:0]  test;
  logic [1:0]  pump;
  logic [1:0]  demand;
  logic [1:0]  freeze;
  logic [1:0]  exer_go;
  logic signed [9:0] hi;
  logic signed [9:0] lo;
  logic        no_buf;
  logic        flue_ok;
  logic        burning;

  assign req  = read_i | write_i;
  assign acc  = req & ~waitrequest_o;
  assign mode = hpc_mode_e'(ctrl[CTRL_MODE_LSB +: 2]);
  assign test = ctrl[CTRL_TEST_LSB +: 2];

  always_ff @(posedge clk_i) begin
    if (srst_i || div == 25'(TICK_N - 1)) begin
      div <= 25'h0000000;
    end else begin
      div <= div + 25'h0000001;
    end
  end

  always_ff @(posedge clk_i) begin
    tick <= !srst_i && div == 25'(TICK_N - 1);
  end

  // One wait cycle per access gives read data a full cycle to settle.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      waitrequest_o <= 1'b1;
    end else begin
      waitrequest_o <= !(req && waitrequest_o);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && waitrequest_o) begin
      case (address_i & 6'h3C)
        OFS_CTRL: readdata_o <= ctrl;
        OFS_THR:  readdata_o <= thr;
        OFS_LIM:  readdata_o <= lim;
        OFS_RTC:  readdata_o <= rtc;
        OFS_STAT: readdata_o <= {16'h0000, clean_left_o, 1'b0, buf_lo_ok_i, buf_hi_ok_i,
                                 touch_o, unlocked, 1'b0, pump};
        OFS_IRQ:  readdata_o <= {28'h0000000, irq_st};
        OFS_MASK: readdata_o <= {28'h0000000, irq_mask};
        default:  readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  logic wr_ctrl;
  logic wr_prot;
  assign wr_ctrl = acc && write_i && (address_i & 6'h3C) == OFS_CTRL;
  assign wr_prot = acc && write_i && unlocked &&
                   ((address_i & 6'h3C) == OFS_THR || (address_i & 6'h3C) == OFS_LIM ||
                    (address_i & 6'h3C) == OFS_CODE);

  // The cleaning bit is a one-shot request and never stored.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl <= 32'h0000_0001;
    end else if (wr_ctrl) begin
      ctrl <= merge(ctrl, writedata_i, byteenable_i) & 32'h0000_000F;
    end
  end

  // Protected settings only change while the PIN unlock is running.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      thr  <= THR_RST;
      lim  <= LIM_RST;
      code <= CODE_RST;
    end else if (wr_prot) begin
      case (address_i & 6'h3C)
        OFS_THR: thr  <= merge(thr, writedata_i, byteenable_i);
        OFS_LIM: lim  <= merge(lim, writedata_i, byteenable_i);
        default: code <= 16'(merge({16'h0000, code}, writedata_i, byteenable_i));
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      nv_save_o <= 1'b0;
    end else begin
      nv_save_o <= wr_ctrl || wr_prot ||
                   (acc && write_i && (address_i & 6'h3C) == OFS_RTC);
    end
  end

  // Weekday stays in 1..7; the correction byte is stored but no logic uses it.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rtc <= RTC_RST;
      sec <= 6'h00;
    end else if (acc && write_i && (address_i & 6'h3C) == OFS_RTC) begin
      rtc <= merge(rtc, writedata_i, byteenable_i) & 32'hFF3F_1F07;
      if (byteenable_i[0] && writedata_i[2:0] == 3'h0) begin
        rtc[2:0] <= 3'h1;
      end
      sec <= 6'h00;
    end else if (tick) begin
      sec <= (sec == 6'h3B) ? 6'h00 : sec + 6'h01;
      if (sec == 6'h3B) begin
        rtc[21:16] <= (rtc[21:16] >= 6'h3B) ? 6'h00 : rtc[21:16] + 6'h01;
        if (rtc[21:16] >= 6'h3B) begin
          rtc[12:8] <= (rtc[12:8] >= 5'h17) ? 5'h00 : rtc[12:8] + 5'h01;
          if (rtc[12:8] >= 5'h17) begin
            rtc[2:0] <= (rtc[2:0] >= 3'h7) ? 3'h1 : rtc[2:0] + 3'h1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      unlock_cnt <= 11'h000;
    end else if (acc && write_i && (address_i & 6'h3C) == OFS_PIN &&
                 writedata_i[15:0] == code) begin
      unlock_cnt <= 11'(UNLOCK_S);
    end else if (tick && unlock_cnt != 11'h000) begin
      unlock_cnt <= unlock_cnt - 11'h001;
    end
  end
  assign unlocked = unlock_cnt != 11'h000;

  // Touches are dropped while the countdown runs; the count is shown as it falls.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clean_left_o <= 8'h00;
    end else if (wr_ctrl && byteenable_i[0] && writedata_i[CTRL_CLEAN_BIT]) begin
      clean_left_o <= 8'(CLEAN_S);
    end else if (tick && clean_left_o != 8'h00) begin
      clean_left_o <= clean_left_o - 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      touch_o <= 1'b0;
    end else begin
      touch_o <= touch_i && clean_left_o == 8'h00 &&
                 !(wr_ctrl && byteenable_i[0] && writedata_i[CTRL_CLEAN_BIT]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_cnt <= 9'h000;
    end else if (tick && boot_cnt != 9'(BOOT_S)) begin
      boot_cnt <= boot_cnt + 9'h001;
    end
  end
  assign boot_end = tick && boot_cnt == 9'(BOOT_S - 1);

  always_comb begin
    no_buf = !buf_hi_ok_i && !buf_lo_ok_i;
    hi = buf_hi_ok_i ? temps_i.buf_hi : temps_i.buf_lo;
    lo = buf_lo_ok_i ? temps_i.buf_lo : temps_i.buf_hi;
    burning = above(temps_i.flue, thr.loading_flue_threshold, pump[0], lim.hyst_c);
    flue_ok = thr.loading_flue_threshold == 8'h00 || burning;
    demand = 2'b00;
    if (mode != HPC_AIR) begin
      if (no_buf) begin
        demand[0] = flue_ok &&
                    (thr.loading_flue_threshold != 8'h00 ||
                     above(temps_i.stove, thr.stove_water_min, pump[0], lim.hyst_c));
        demand[1] = demand[0];
      end else begin
        demand[0] = flue_ok &&
                    above(temps_i.stove, thr.stove_water_min, pump[0], lim.hyst_c) &&
                    $signed({{2{temps_i.stove[9]}}, temps_i.stove}) >=
                    $signed({{2{lo[9]}}, lo}) + $signed({4'h0, thr.stove_buffer_delta});
        if (!burning && above(temps_i.stove, lim.alarm_max - AFTERBURN_C,
                              pump[0], lim.hyst_c)) begin
          demand[0] = 1'b1;
        end
        demand[1] = above(hi, thr.circ_upper_threshold, pump[1], lim.hyst_c);
      end
    end
    freeze[0] = mode != HPC_AIR && temps_i.stove < FREEZE_C;
    freeze[1] = mode != HPC_AIR && (no_buf ? temps_i.stove : hi) < FREEZE_C;
  end

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pump
      logic [18:0] idle;
      logic [4:0]  run;
      logic [7:0]  hold;
      logic        ran;

      assign exer_go[p] = mode != HPC_AIR && run == 5'h00 &&
                          ((tick && idle >= 19'(IDLE_S - 1)) || (boot_end && !ran));

      always_ff @(posedge clk_i) begin
        if (srst_i || pump[p]) begin
          idle <= 19'h00000;
        end else if (tick) begin
          idle <= idle + 19'h00001;
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          ran <= 1'b0;
        end else if (pump[p]) begin
          ran <= 1'b1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          run <= 5'h00;
        end else if (exer_go[p]) begin
          run <= 5'(EXER_RUN_S);
        end else if (tick && run != 5'h00) begin
          run <= run - 5'h01;
        end
      end

      // Minimum time keeps a pump from chattering around its thresholds.
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pump[p] <= 1'b0;
          hold    <= 8'h00;
        end else if (tick) begin
          if (test[p] || freeze[p] || (mode != HPC_AIR && run != 5'h00)) begin
            pump[p] <= 1'b1;
          end else if (mode == HPC_AIR) begin
            pump[p] <= 1'b0;
          end else if (hold != 8'h00) begin
            hold <= hold - 8'h01;
          end else if (demand[p] != pump[p]) begin
            pump[p] <= demand[p];
            hold    <= lim.min_on_s;
          end
        end
      end
      AST_EXER: assert property (@(posedge clk_i) disable iff (srst_i)
        tick && run != 5'h00 && mode != HPC_AIR |=> pump[p])
        else $error("exercise run missing");
    end
  endgenerate

  assign buf_pump_o  = pump[0];
  assign circ_pump_o = pump[1];

  always_comb begin
    ev = '0;
    ev[IRQ_UNLOCK_END] = tick && unlock_cnt == 11'h001;
    ev[IRQ_CLEAN_END]  = tick && clean_left_o == 8'h01;
    ev[IRQ_FREEZE]     = tick && (freeze != 2'b00);
    ev[IRQ_EXERCISE]   = exer_go != 2'b00;
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_st <= '0;
    end else if (acc && write_i && (address_i & 6'h3C) == OFS_IRQ && byteenable_i[0]) begin
      irq_st <= (irq_st & ~writedata_i[IRQ_W-1:0]) | ev;
    end else begin
      irq_st <= irq_st | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_mask <= '0;
    end else if (acc && write_i && (address_i & 6'h3C) == OFS_MASK && byteenable_i[0]) begin
      irq_mask <= writedata_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    irq_o <= !srst_i && |(irq_st & irq_mask);
  end

  sequence s_pin_ok;
    acc && write_i && (address_i & 6'h3C) == OFS_PIN && writedata_i[15:0] == code;
  endsequence
  sequence s_locked_thr;
    acc && write_i && (address_i & 6'h3C) == OFS_THR && !unlocked;
  endsequence

  AST_AIR_OFF: assert property (@(posedge clk_i) disable iff (srst_i)
    tick && mode == HPC_AIR && test == 2'b00 |=> pump == 2'b00)
    else $error("pump on in air mode");
  AST_TEST_ON: assert property (@(posedge clk_i) disable iff (srst_i)
    tick && test[1] |=> circ_pump_o)
    else $error("test mode did not force pump");
  AST_FREEZE: assert property (@(posedge clk_i) disable iff (srst_i)
    tick && freeze[0] |=> buf_pump_o)
    else $error("antifreeze did not start pump");
  AST_TICK_ONLY: assert property (@(posedge clk_i) disable iff (srst_i)
    !tick |=> $stable(pump))
    else $error("pump changed off tick");
  AST_UNLOCK: assert property (@(posedge clk_i) disable iff (srst_i)
    s_pin_ok |=> unlocked && unlock_cnt == 11'(UNLOCK_S))
    else $error("PIN did not unlock");
  AST_LOCKED: assert property (@(posedge clk_i) disable iff (srst_i)
    s_locked_thr |=> $stable(thr))
    else $error("locked write changed settings");
  AST_CLEAN: assert property (@(posedge clk_i) disable iff (srst_i)
    clean_left_o != 8'h00 |=> !touch_o)
    else $error("touch passed during cleaning");
  AST_SAVE: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_ctrl |=> nv_save_o)
    else $error("setting write without save");
  AST_WEEKDAY: assert property (@(posedge clk_i) disable iff (srst_i)
    rtc[2:0] >= 3'h1 && rtc[2:0] <= 3'h7)
    else $error("weekday out of range");
endmodule
